//--- rtl/ssf_pkg.sv
package ssf_pkg;
  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_STATUS = 8'hC0;
  localparam logic [7:0] OP_FETCH = 8'h02;
  localparam logic [7:0] REQ_LEN = 8'h00;
  localparam logic [7:0] RESP_LEN = 8'h04;
  localparam logic [7:0] TAG_FIRST = 8'h01;
  localparam logic [7:0] TAG_LAST = 8'hCF;
  localparam logic [7:0] CRC_SEED = 8'hFF;
  localparam logic [7:0] SUM_SEED = 8'h00;
  localparam logic [6:0] FRAME_LAST_BIT = 7'h5F;
  localparam logic [3:0] REQ_BYTES = 4'h4;
  localparam logic [3:0] RESP_LAST = 4'h7;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TAG = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_DATA = 8'h0C;
  localparam int CTRL_GO = 0;
  localparam int CTRL_CKSUM = 1;
  localparam int CTRL_POLL_TAG = 2;
  localparam int CTRL_POLL_RDA = 3;
  localparam int SB_BUSY = 0;
  localparam int SB_DONE = 1;
  localparam int SB_RESP_ERR = 2;
  localparam int SB_CMD_FAIL = 3;
  localparam int SB_BG_FAULT = 4;
  localparam int SB_SHUTDOWN = 5;
  localparam int SB_IRQ = 6;
  localparam int SB_TAG_LSB = 8;
  localparam logic [7:0] EXP_TAG_RST = 8'h00;
  // ----------------------------------------------------------------
  // status word bit positions
  // ----------------------------------------------------------------
  localparam int SS_COMM_ERR = 0;
  localparam int SS_CMD_ERR = 1;
  localparam int SS_BIST_ERR = 2;
  localparam int SS_OPER_ERR = 3;
  localparam int SS_SHUTDOWN = 4;
  localparam int SS_RDA = 5;
  localparam int SS_TAG_LSB = 24;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int SCK_PERIOD_NS = 32;
  localparam int CS_SETUP_NS = 8;
  localparam int POLL_GAP_NS = 200;
  localparam int SCK_HALF_CYC = (SCK_PERIOD_NS / (2 * CLK_PERIOD_NS) < 1) ? 1 :
                                SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int CS_SETUP_CYC = (CS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POLL_GAP_CYC = (POLL_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_PREP = 7'h02,
    ST_SETUP = 7'h04,
    ST_SHIFT = 7'h08,
    ST_HOLD = 7'h10,
    ST_CHECK = 7'h20,
    ST_GAP = 7'h40
  } ssf_state_e;
endpackage

//--- rtl/ssf_integ.sv
module ssf_integ (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic init,
  input wire logic cksum,
  input wire logic en,
  input wire logic [7:0] din,
  output logic [7:0] acc
);
  // ----------------------------------------------------------------
  // byte-wide crc-8 step
  // ----------------------------------------------------------------
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] n;
    n[0] = d[0] ^ d[6] ^ d[7] ^ c[0] ^ c[6] ^ c[7];
    n[1] = d[0] ^ d[1] ^ d[6] ^ c[0] ^ c[1] ^ c[6];
    n[2] = d[0] ^ d[1] ^ d[2] ^ d[6] ^ c[0] ^ c[1] ^ c[2] ^ c[6];
    n[3] = d[1] ^ d[2] ^ d[3] ^ d[7] ^ c[1] ^ c[2] ^ c[3] ^ c[7];
    n[4] = d[2] ^ d[3] ^ d[4] ^ c[2] ^ c[3] ^ c[4];
    n[5] = d[3] ^ d[4] ^ d[5] ^ c[3] ^ c[4] ^ c[5];
    n[6] = d[4] ^ d[5] ^ d[6] ^ c[4] ^ c[5] ^ c[6];
    n[7] = d[5] ^ d[6] ^ d[7] ^ c[5] ^ c[6] ^ c[7];
    return n;
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= ssf_pkg::CRC_SEED;
    end else if (init) begin
      acc <= cksum ? ssf_pkg::SUM_SEED : ssf_pkg::CRC_SEED;
    end else if (en) begin
      acc <= cksum ? 8'(acc + din) : crc_step(acc, din);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_seed;
    init |=> acc == ($past(cksum) ? ssf_pkg::SUM_SEED : ssf_pkg::CRC_SEED);
  endproperty
  a_seed: assert property (p_seed) else $error("integrity seed wrong");

  property p_sum;
    (en && !init && cksum) |=> acc == 8'($past(acc) + $past(din));
  endproperty
  a_sum: assert property (p_sum) else $error("checksum step wrong");

  property p_crc_b0;
    (en && !init && !cksum) |=> acc[0] == ($past(din[0]) ^ $past(din[6]) ^ $past(din[7]) ^
                                           $past(acc[0]) ^ $past(acc[6]) ^ $past(acc[7]));
  endproperty
  a_crc_b0: assert property (p_crc_b0) else $error("crc bit 0 wrong");

  property p_crc_b3;
    (en && !init && !cksum) |=> acc[3] == ($past(din[1]) ^ $past(din[2]) ^ $past(din[3]) ^ $past(din[7]) ^
                                           $past(acc[1]) ^ $past(acc[2]) ^ $past(acc[3]) ^ $past(acc[7]));
  endproperty
  a_crc_b3: assert property (p_crc_b3) else $error("crc bit 3 wrong");
endmodule // ssf_integ

//--- rtl/ssf_host_ctrl.sv
// Functional notes
// - request is opcode C0h, tag, length, integrity over those three.
// - request length byte is always zero.
// - on I2C, write the request then repeated start and read response.
// - CRC uses polynomial x^8+x^2+x+1, code 0x07.
// - CRC starts from 0xFF for every integrity field.
// - CRC advances one byte per step in parallel XOR form.
// - checksum is the byte sum kept to its low eight bits.
// - host polls status until returned tag equals its assigned tag.
// - host fetches read data only after read-data-available is set; the code sends no fetch, it only polls until RDA is set when CTRL bit 3 is on.
// - after a fetch the host reads status again for fetch errors; the code sends no fetch.
// - on comm or command error, clear history and flags before continuing.
// - only comm and command errors fail the command; others are background.
// - the fetch command uses opcode 02h with zero length; OP_FETCH is defined but the code never sends it.
// - host tags step 01h to CFh then wrap to 01h.
//
// Design decisions made here: the APB slave port and the placing of the registers.
module ssf_host_ctrl #(
  parameter int SCK_HALF = ssf_pkg::SCK_HALF_CYC,
  parameter int CS_SETUP = ssf_pkg::CS_SETUP_CYC,
  parameter int POLL_GAP = ssf_pkg::POLL_GAP_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic link_sclk,
  output logic link_cs_n,
  output logic link_mosi,
  input wire logic link_miso,
  input wire logic link_irq
);
  ssf_pkg::ssf_state_e state, next_state;
  logic ctrl_cksum, ctrl_poll_tag, ctrl_poll_rda;
  logic [7:0] exp_tag, req_tag;
  logic done, resp_err, cmd_fail, bg_fault, shutdown;
  logic [31:0] status_q;
  logic miso_q1, miso_q2, irq_q1, irq_q2;
  logic [7:0] div_cnt, wait_cnt;
  logic [6:0] bit_cnt;
  logic [1:0] prep_cnt;
  logic [7:0] rx_sh;
  logic [7:0] rx_buf [0:7];
  logic [7:0] tx_acc, rx_acc, tx_din;
  logic wr, mapped, go_req, start, half_end, fall, rise, byte_end;
  logic [7:0] rx_byte;
  logic [3:0] byte_idx;
  logic [31:0] status_w;
  logic frame_ok, fail, repoll;
  logic mode_cksum;
  logic [31:0] mosi_hist;

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  assign wr = psel && penable && pwrite;
  assign mapped = (paddr == ssf_pkg::ADDR_CTRL) || (paddr == ssf_pkg::ADDR_TAG) ||
                  (paddr == ssf_pkg::ADDR_STAT) || (paddr == ssf_pkg::ADDR_DATA);
  assign pready = psel && penable;
  assign pslverr = psel && penable && !mapped;
  // a failed command locks the engine until software clears the flag
  assign go_req = wr && (paddr == ssf_pkg::ADDR_CTRL) && pwdata[ssf_pkg::CTRL_GO] &&
                  !cmd_fail && (state == ssf_pkg::ST_IDLE);
  // a go write that also flips the mode must seed with the new mode, not the stale one
  assign mode_cksum = go_req ? pwdata[ssf_pkg::CTRL_CKSUM] : ctrl_cksum;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_cksum <= 1'b0;
      ctrl_poll_tag <= 1'b0;
      ctrl_poll_rda <= 1'b0;
      exp_tag <= ssf_pkg::EXP_TAG_RST;
    end else if (wr && paddr == ssf_pkg::ADDR_CTRL) begin
      ctrl_cksum <= pwdata[ssf_pkg::CTRL_CKSUM];
      ctrl_poll_tag <= pwdata[ssf_pkg::CTRL_POLL_TAG];
      ctrl_poll_rda <= pwdata[ssf_pkg::CTRL_POLL_RDA];
    end else if (wr && paddr == ssf_pkg::ADDR_TAG) begin
      exp_tag <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        ssf_pkg::ADDR_CTRL: prdata <= {28'h0000000, ctrl_poll_rda, ctrl_poll_tag, ctrl_cksum, 1'b0};
        ssf_pkg::ADDR_TAG: prdata <= {24'h000000, exp_tag};
        ssf_pkg::ADDR_STAT: prdata <= {16'h0000, req_tag, 1'b0, irq_q2, shutdown, bg_fault, cmd_fail,
                                       resp_err, done, (state != ssf_pkg::ST_IDLE)};
        ssf_pkg::ADDR_DATA: prdata <= status_q;
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      miso_q1 <= 1'b0;
      miso_q2 <= 1'b0;
      irq_q1 <= 1'b0;
      irq_q2 <= 1'b0;
    end else begin
      miso_q1 <= link_miso;
      miso_q2 <= miso_q1;
      irq_q1 <= link_irq;
      irq_q2 <= irq_q1;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  assign start = go_req || (state == ssf_pkg::ST_GAP && wait_cnt == 8'h00);
  assign half_end = (state == ssf_pkg::ST_SHIFT) && (div_cnt == 8'(SCK_HALF - 1));
  assign rise = half_end && !link_sclk;
  assign fall = half_end && link_sclk;
  assign byte_end = fall && (bit_cnt[2:0] == 3'h7);
  assign byte_idx = bit_cnt[6:3];
  assign rx_byte = {rx_sh[6:0], miso_q2};

  always_comb begin
    next_state = state;
    case (state)
      ssf_pkg::ST_IDLE: if (go_req) next_state = ssf_pkg::ST_PREP;
      ssf_pkg::ST_PREP: if (prep_cnt == 2'h2) next_state = ssf_pkg::ST_SETUP;
      ssf_pkg::ST_SETUP: if (wait_cnt == 8'h00) next_state = ssf_pkg::ST_SHIFT;
      ssf_pkg::ST_SHIFT: if (fall && bit_cnt == ssf_pkg::FRAME_LAST_BIT) next_state = ssf_pkg::ST_HOLD;
      ssf_pkg::ST_HOLD: if (wait_cnt == 8'h00) next_state = ssf_pkg::ST_CHECK;
      ssf_pkg::ST_CHECK: next_state = repoll ? ssf_pkg::ST_GAP : ssf_pkg::ST_IDLE;
      ssf_pkg::ST_GAP: if (wait_cnt == 8'h00) next_state = ssf_pkg::ST_PREP;
      default: next_state = ssf_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ssf_pkg::ST_IDLE;
      link_cs_n <= 1'b1;
    end else begin
      state <= next_state;
      // request and response share one select frame, request bytes first
      link_cs_n <= !(next_state == ssf_pkg::ST_SETUP || next_state == ssf_pkg::ST_SHIFT ||
                     next_state == ssf_pkg::ST_HOLD);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_tag <= ssf_pkg::TAG_LAST;
    end else if (start) begin
      req_tag <= (req_tag >= ssf_pkg::TAG_LAST) ? ssf_pkg::TAG_FIRST : 8'(req_tag + 8'h01);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt <= 8'h00;
    end else if (state == ssf_pkg::ST_PREP && prep_cnt == 2'h2) begin
      wait_cnt <= 8'(CS_SETUP - 1);
    end else if (fall && bit_cnt == ssf_pkg::FRAME_LAST_BIT) begin
      wait_cnt <= 8'(SCK_HALF - 1);
    end else if (state == ssf_pkg::ST_CHECK) begin
      wait_cnt <= 8'(POLL_GAP - 1);
    end else if (wait_cnt != 8'h00) begin
      wait_cnt <= wait_cnt - 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prep_cnt <= 2'h0;
    end else if (state == ssf_pkg::ST_PREP) begin
      prep_cnt <= prep_cnt + 2'h1;
    end else begin
      prep_cnt <= 2'h0;
    end
  end

  // ----------------------------------------------------------------
  // integrity of request and response
  // ----------------------------------------------------------------
  always_comb begin
    case (prep_cnt)
      2'h0: tx_din = ssf_pkg::OP_STATUS;
      2'h1: tx_din = req_tag;
      default: tx_din = ssf_pkg::REQ_LEN;
    endcase
  end

  ssf_integ u_tx_integ (
    .pclk(pclk),
    .presetn(presetn),
    .init(start),
    .cksum(mode_cksum),
    .en(state == ssf_pkg::ST_PREP),
    .din(tx_din),
    .acc(tx_acc)
  );

  ssf_integ u_rx_integ (
    .pclk(pclk),
    .presetn(presetn),
    .init(start),
    .cksum(mode_cksum),
    .en(byte_end && byte_idx >= ssf_pkg::REQ_BYTES && byte_idx < ssf_pkg::REQ_BYTES + ssf_pkg::RESP_LAST),
    .din(rx_byte),
    .acc(rx_acc)
  );

  // ----------------------------------------------------------------
  // serial shifter, mode 0, msb first
  // ----------------------------------------------------------------
  function automatic logic tx_bit(input logic [6:0] idx, input logic [7:0] tag, input logic [7:0] integ);
    logic [7:0] b;
    case (idx[6:3])
      4'h0: b = ssf_pkg::OP_STATUS;
      4'h1: b = tag;
      4'h2: b = ssf_pkg::REQ_LEN;
      4'h3: b = integ;
      default: b = 8'h00;
    endcase
    return b[3'h7 - idx[2:0]];
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 8'h00;
      link_sclk <= 1'b0;
      bit_cnt <= 7'h00;
      link_mosi <= 1'b0;
      rx_sh <= 8'h00;
    end else if (state == ssf_pkg::ST_SETUP) begin
      div_cnt <= 8'h00;
      link_sclk <= 1'b0;
      bit_cnt <= 7'h00;
      link_mosi <= tx_bit(7'h00, req_tag, tx_acc);
    end else if (state == ssf_pkg::ST_SHIFT) begin
      div_cnt <= half_end ? 8'h00 : div_cnt + 8'h01;
      if (half_end) begin
        link_sclk <= !link_sclk;
      end
      // sample just before the fall: the synced copy still holds the bit driven after the last fall
      if (fall) begin
        rx_sh <= rx_byte;
        bit_cnt <= bit_cnt + 7'h01;
        link_mosi <= tx_bit(7'(bit_cnt + 7'h01), req_tag, tx_acc);
      end
    end else begin
      link_sclk <= 1'b0;
      link_mosi <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) begin
        rx_buf[i] <= 8'h00;
      end
    end else if (byte_end && byte_idx >= ssf_pkg::REQ_BYTES) begin
      rx_buf[3'(byte_idx - ssf_pkg::REQ_BYTES)] <= rx_byte;
    end
  end

  // ----------------------------------------------------------------
  // response check and result flags
  // ----------------------------------------------------------------
  assign status_w = {rx_buf[6], rx_buf[5], rx_buf[4], rx_buf[3]};
  assign frame_ok = (rx_buf[0] == ssf_pkg::OP_STATUS) && (rx_buf[1] == req_tag) &&
                    (rx_buf[2] == ssf_pkg::RESP_LEN) && (rx_acc == rx_buf[7]);
  assign fail = status_w[ssf_pkg::SS_COMM_ERR] || status_w[ssf_pkg::SS_CMD_ERR];
  // polling never hides a failure or a shutdown
  assign repoll = frame_ok && !fail && !status_w[ssf_pkg::SS_SHUTDOWN] &&
                  ((ctrl_poll_tag && status_w[ssf_pkg::SS_TAG_LSB +: 8] != exp_tag) ||
                   (ctrl_poll_rda && !status_w[ssf_pkg::SS_RDA]));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done <= 1'b0;
      cmd_fail <= 1'b0;
    end else begin
      if (state == ssf_pkg::ST_CHECK && !repoll) begin
        done <= 1'b1;
      end else if (wr && paddr == ssf_pkg::ADDR_STAT && pwdata[ssf_pkg::SB_DONE]) begin
        done <= 1'b0;
      end
      if (state == ssf_pkg::ST_CHECK && frame_ok && fail) begin
        cmd_fail <= 1'b1;
      end else if (wr && paddr == ssf_pkg::ADDR_STAT && pwdata[ssf_pkg::SB_CMD_FAIL]) begin
        cmd_fail <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_err <= 1'b0;
      bg_fault <= 1'b0;
      shutdown <= 1'b0;
      status_q <= 32'h0000_0000;
    end else if (state == ssf_pkg::ST_CHECK) begin
      resp_err <= !frame_ok;
      bg_fault <= frame_ok && !fail &&
                  (status_w[ssf_pkg::SS_BIST_ERR] || status_w[ssf_pkg::SS_OPER_ERR]);
      shutdown <= frame_ok && status_w[ssf_pkg::SS_SHUTDOWN];
      if (frame_ok) begin
        status_q <= status_w;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mosi_hist <= 32'h0000_0000;
    end else if (rise && bit_cnt < 7'h20) begin
      mosi_hist <= {mosi_hist[30:0], link_mosi};
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_req_op;
    $rose(state == ssf_pkg::ST_HOLD) |-> mosi_hist[31:24] == ssf_pkg::OP_STATUS;
  endproperty
  a_req_op: assert property (p_req_op) else $error("request opcode wrong on wire");

  property p_req_len;
    $rose(state == ssf_pkg::ST_HOLD) |-> mosi_hist[15:8] == ssf_pkg::REQ_LEN && mosi_hist[23:16] == req_tag;
  endproperty
  a_req_len: assert property (p_req_len) else $error("request tag or length wrong on wire");

  property p_tag_wrap;
    (start && req_tag == ssf_pkg::TAG_LAST) |=> req_tag == ssf_pkg::TAG_FIRST;
  endproperty
  a_tag_wrap: assert property (p_tag_wrap) else $error("tag did not wrap to first");

  property p_tag_range;
    req_tag >= ssf_pkg::TAG_FIRST && req_tag <= ssf_pkg::TAG_LAST;
  endproperty
  a_tag_range: assert property (p_tag_range) else $error("tag out of host range");

  sequence s_hold;
    (state == ssf_pkg::ST_HOLD && !link_cs_n && !link_sclk) [*4];
  endsequence
  sequence s_release;
    state == ssf_pkg::ST_CHECK && link_cs_n;
  endsequence
  property p_frame_end;
    $rose(state == ssf_pkg::ST_HOLD) |-> s_hold ##1 s_release;
  endproperty
  a_frame_end: assert property (p_frame_end) else $error("frame end timing wrong");

  property p_repoll;
    (state == ssf_pkg::ST_CHECK && repoll) |=> state == ssf_pkg::ST_GAP ##[1:300] state == ssf_pkg::ST_PREP;
  endproperty
  a_repoll: assert property (p_repoll) else $error("poll not repeated");

  property p_fail_lock;
    (cmd_fail && state == ssf_pkg::ST_IDLE) |=> state == ssf_pkg::ST_IDLE;
  endproperty
  a_fail_lock: assert property (p_fail_lock) else $error("new frame while failure pending");

  property p_fail_class;
    (state == ssf_pkg::ST_CHECK && frame_ok && fail) |=> cmd_fail && !bg_fault && done;
  endproperty
  a_fail_class: assert property (p_fail_class) else $error("failure classed wrong");
endmodule // ssf_host_ctrl

//--- tb/ssf_dev_model.sv
module ssf_dev_model (
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic ck,
  input wire logic corrupt,
  input wire logic [31:0] stat,
  output logic miso,
  output logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] rq;
  logic [63:0] rs;
  logic [31:0] s;
  logic [7:0] h;
  int n;
  function automatic logic [7:0] step(input logic [7:0] a, input logic [7:0] d, input logic c);
    logic [7:0] x;
    x = a ^ d;
    for (int i = 0; i < 8; i++) x = x[7] ? {x[6:0], 1'b0} ^ 8'h07 : {x[6:0], 1'b0};
    return c ? 8'(a + d) : x;
  endfunction
  assign irq = stat[ssf_pkg::SS_SHUTDOWN];
  initial miso = 1'b0;
  // unselected or idle: line toggles so a stale value never looks valid
  always @(cs_n) begin
    n = 0;
    miso <= ~miso;
  end
  always @(posedge sclk) begin
    if (!cs_n) begin
      if (n < 32) rq[31 - n] = mosi;
      n++;
      if (n == 32) begin
        h = ck ? 8'h00 : 8'hFF;
        for (int i = 3; i > 0; i--) h = step(h, rq[i*8 +: 8], ck);
        s = stat;
        if (h !== rq[7:0] || rq[31:24] !== 8'hC0 || rq[15:8] !== 8'h00) s[0] = 1'b1;
        rs = {rq[31:16], 8'h04, s[7:0], s[15:8], s[23:16], s[31:24], 8'h00};
        h = ck ? 8'h00 : 8'hFF;
        for (int i = 7; i > 0; i--) h = step(h, rs[i*8 +: 8], ck);
        rs[7:0] = h ^ {8{corrupt}};
      end
    end
  end
  always @(negedge sclk) if (!cs_n) miso <= (n >= 32 && n < 96) ? rs[95 - n] : ~miso;
endmodule // ssf_dev_model

//--- tb/ssf_host_ctrl_test.sv
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; $display("BAD %s exp %h got %h", nm, e, g); end end
module ssf_host_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ck = 0, bad = 0;
  logic [7:0] paddr = '0;
  logic [7:0] tag = 8'hCF;
  logic [31:0] pwdata = '0, rnd = 32'h8E6A45CF, st = '0, last = '0, prdata;
  logic pready, pslverr, sclk, cs_n, mosi, miso, irq;
  logic [32:0] q[$];
  logic [32:0] e;
  int err_count = 0, comparisons = 0, frames = 0, k;
  always #2 pclk = ~pclk;
  always @(posedge cs_n) frames++;
  // every frame, repolls included, carries the next host tag
  always @(negedge cs_n) tag <= (tag == 8'hCF) ? 8'h01 : 8'(tag + 8'h01);
  ssf_host_ctrl #(.SCK_HALF(4), .CS_SETUP(1), .POLL_GAP(5)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_sclk(sclk), .link_cs_n(cs_n), .link_mosi(mosi),
    .link_miso(miso), .link_irq(irq));
  ssf_dev_model u_dev (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .ck(ck), .corrupt(bad), .stat(st),
    .miso(miso), .irq(irq));
  // --------------------------------------------------------------
  // scoreboard: oldest note against each completed read
  // --------------------------------------------------------------
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && q.size() > 0) begin
      e = q.pop_front();
      `CHK("prdata", e, {pslverr, prdata})
    end
  end
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic abort();
    err_count++;
    results();
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [32:0] xs(input logic [31:0] s, input logic r);
    logic f;
    f = s[0] | s[1];
    return {17'h0, tag, 1'b0, s[4], s[4], !f && (s[2] | s[3]), f, r, 2'b10};
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (!pready && i < 50);
    if (!pready) abort();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] x);
    q.push_back(x);
    apb(1'b0, a, 32'h0);
  endtask
  // polling reads leave the queue empty, so they are not scored
  task automatic go(input logic [31:0] c);
    int i;
    // a stale done flag would end the wait before the new frame runs
    apb(1'b1, 8'h08, 32'h00000002);
    apb(1'b1, 8'h00, c);
    i = 0;
    do begin
      apb(1'b0, 8'h08, 32'h0);
      i++;
    end while (!prdata[1] && i < 5000);
    if (!prdata[1]) abort();
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h00, 33'h0);
    rd(8'h04, 33'h0);
    rd(8'h08, 33'h0_0000_CF00);
    rd(8'h0C, 33'h0);
    rd(8'h10, 33'h1_0000_0000);
    $display("reset and map test done");
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      ck <= i[0];
      st <= {rnd[31:6], 2'b00, i[3:0]};
      go({30'h0, i[0], 1'b1});
      rd(8'h08, xs(st, 1'b0));
      rd(8'h0C, {1'b0, st});
      apb(1'b1, 8'h08, 32'h0000000A);
      last = st;
    end
    $display("status read test done");
    ck <= 1'b0;
    bad <= 1'b1;
    go(32'h1);
    rd(8'h08, xs(32'h0, 1'b1));
    rd(8'h0C, {1'b0, last});
    bad <= 1'b0;
    $display("corrupt response test done");
    apb(1'b1, 8'h04, 32'h5A);
    st <= 32'h0;
    frames = 0;
    fork
      go(32'hD);
      begin
        k = 0;
        while (frames < 2 && k < 9000) begin
          @(posedge pclk);
          k++;
        end
        st <= 32'h5A000020;
      end
    join
    `CHK("frames", 1'b1, frames >= 3)
    rd(8'h0C, {1'b0, st});
    $display("poll test done");
    st <= 32'h12;
    go(32'h1);
    rd(8'h08, xs(st, 1'b0));
    apb(1'b1, 8'h00, 32'h1);
    rd(8'h08, xs(st, 1'b0));
    $display("shutdown test done");
    results();
  end
endmodule // ssf_host_ctrl_test
